// ==== pkg/kbi_pkg.sv ====
// package for the keypad and external-pin interrupt unit
// assumes an apb slave with 32-bit data, registers in the low byte
`default_nettype none
package kbi_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_STATUS_CTRL = 12'h01a;
    localparam logic [11:0] IDX_PIN_ENABLE  = 12'h01b;
    localparam logic [11:0] ADDR_STATUS_CTRL = {IDX_STATUS_CTRL[9:0], 2'b00};
    localparam logic [11:0] ADDR_PIN_ENABLE  = {IDX_PIN_ENABLE[9:0], 2'b00};
    // field positions in the status and control register
    localparam int BIT_EXT_PENDING = 7;
    localparam int BIT_EXT_ACK     = 6;
    localparam int BIT_EXT_MASK    = 5;
    localparam int BIT_EXT_SENSE   = 4;
    localparam int BIT_KP_PENDING  = 3;
    localparam int BIT_KP_ACK      = 2;
    localparam int BIT_KP_MASK     = 1;
    localparam int BIT_KP_SENSE    = 0;
    // keypad enable field occupies bits 6:1
    localparam int KP_PINS         = 6;
    localparam int KP_EN_LSB       = 1;
    // reset values
    localparam logic [3:0] CTRL_RESET   = 4'h0;
    localparam logic [5:0] KP_EN_RESET  = 6'h00;
    localparam logic [6:0] PIN_IDLE     = 7'h7f;

    // writable control fields of the status and control register
    typedef struct packed {
        logic ext_mask;
        logic ext_sense;
        logic kp_mask;
        logic kp_sense;
    } ctrl_t;
endpackage
`default_nettype wire

// ==== rtl/irq_latch.sv ====
// one interrupt latch with edge or edge-plus-level sensitivity
// assumes low_in is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module irq_latch (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // source and control
    input  wire logic low_in,
    input  wire logic sense_sel,
    input  wire logic ack,
    // state
    output logic      pending
);
    logic low_prev_q;
    logic latch_q;
    logic latch_d;
    logic ack_seen_q;
    logic ack_seen_d;
    wire  set_w;
    wire  clr_w;

    // falling edge of the pin; a held low after reset is not an edge
    assign set_w = low_in & ~low_prev_q;
    // edge mode clears at once, level mode also needs the pin back high
    assign clr_w = sense_sel ? ((ack | ack_seen_q) & ~low_in) : ack;
    // set beats clear so an edge during the ack is kept
    assign latch_d    = set_w | (latch_q & ~clr_w);
    assign ack_seen_d = latch_q & sense_sel & low_in & (ack | ack_seen_q) & ~set_w;
    assign pending    = latch_q;

    // low_prev resets high so reset clears a request even with the pin low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_prev_q <= 1'b1;
            latch_q    <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            low_prev_q <= low_in;
            latch_q    <= latch_d;
            ack_seen_q <= ack_seen_d;
        end
    end

    sequence s_edge_ack;
        ack && !sense_sel && !set_w;
    endsequence
    property p_edge_clear;
        @(posedge clk) disable iff (!rst_n) s_edge_ack |=> !latch_q;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("edge mode ack did not clear latch");

    property p_level_hold;
        @(posedge clk) disable iff (!rst_n)
            (latch_q && sense_sel && low_in) |=> latch_q;
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("level mode latch cleared while pin low");

    property p_edge_set;
        @(posedge clk) disable iff (!rst_n)
            (!low_prev_q && low_in) |=> latch_q;
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("falling edge not latched");

    property p_no_set_held;
        @(posedge clk) disable iff (!rst_n)
            (!latch_q && low_prev_q && !ack_seen_q) |=> !latch_q;
    endproperty
    a_no_set_held: assert property (p_no_set_held)
        else $error("latch set without a new falling edge");
endmodule
`default_nettype wire

// ==== rtl/kbi_unit.sv ====
// keypad and external-pin interrupt unit with apb register access
// assumes pins are asynchronous; cpu side signals share pclk
`timescale 1ns/1ps
`default_nettype none
module kbi_unit (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins, asynchronous
    input  wire logic        ext_pin_n,
    input  wire logic [5:0]  kp_pin,
    // cpu and port side, on pclk
    input  wire logic        vec_ack_ext,
    input  wire logic        vec_ack_kp,
    input  wire logic        break_active,
    input  wire logic        break_clear_enable,
    input  wire logic [5:0]  port_direction,
    // outputs
    output logic             ext_irq_req,
    output logic             kp_irq_req,
    output logic             wake_req,
    output logic [5:0]       pullup_en,
    output logic [5:0]       pin_oe,
    output logic [5:0]       pin_read_sel
);
    kbi_pkg::ctrl_t ctrl_q;
    kbi_pkg::ctrl_t ctrl_d;
    logic [5:0]  kp_en_q;
    logic [5:0]  kp_en_d;
    logic [6:0]  sync1_q;
    logic [6:0]  sync2_q;
    logic [31:0] prdata_d;
    logic        ext_pending;
    logic        kp_pending;
    logic        ext_irq_d;
    logic        kp_irq_d;

    // bus decode
    wire setup_w   = psel & ~penable;
    wire access_w  = psel & penable & pready;
    wire hit_sc_w  = paddr == kbi_pkg::ADDR_STATUS_CTRL;
    wire hit_en_w  = paddr == kbi_pkg::ADDR_PIN_ENABLE;
    wire wr_lane_w = access_w & pwrite & pstrb[0];
    wire wr_sc_w   = wr_lane_w & hit_sc_w;
    wire wr_en_w   = wr_lane_w & hit_en_w;

    // acks from software are held off during break unless allowed
    wire ack_ok_w  = ~break_active | break_clear_enable;
    wire sw_ack_ext_w = wr_sc_w & pwdata[kbi_pkg::BIT_EXT_ACK] & ack_ok_w;
    wire sw_ack_kp_w  = wr_sc_w & pwdata[kbi_pkg::BIT_KP_ACK] & ack_ok_w;
    wire ack_ext_w    = sw_ack_ext_w | vec_ack_ext;
    wire ack_kp_w     = sw_ack_kp_w | vec_ack_kp;

    // only the control fields are writable, flags and reserved ignored
    assign ctrl_d = wr_sc_w ? kbi_pkg::ctrl_t'{
        ext_mask:  pwdata[kbi_pkg::BIT_EXT_MASK],
        ext_sense: pwdata[kbi_pkg::BIT_EXT_SENSE],
        kp_mask:   pwdata[kbi_pkg::BIT_KP_MASK],
        kp_sense:  pwdata[kbi_pkg::BIT_KP_SENSE]} : ctrl_q;
    assign kp_en_d = wr_en_w ?
        pwdata[kbi_pkg::KP_EN_LSB +: kbi_pkg::KP_PINS] : kp_en_q;

    // synced pin levels; bit 6 is the external pin
    wire       ext_low_w = ~sync2_q[6];
    // any enabled keypad pin low; disabled pins never request
    wire       kp_low_w  = |(~sync2_q[5:0] & kp_en_q);

    // read mux; ack bits and reserved bits read zero
    wire [7:0] sc_rd_w = {ext_pending, 1'b0, ctrl_q.ext_mask, ctrl_q.ext_sense,
                          kp_pending, 1'b0, ctrl_q.kp_mask, ctrl_q.kp_sense};
    wire [7:0] en_rd_w = {1'b0, kp_en_q, 1'b0};
    assign prdata_d = (setup_w & ~pwrite & hit_sc_w) ? {24'h000000, sc_rd_w} :
                      (setup_w & ~pwrite & hit_en_w) ? {24'h000000, en_rd_w} :
                      32'h00000000;

    // cpu requests pass only while unmasked; flags do not look at masks
    assign ext_irq_d = ext_pending & ~ctrl_q.ext_mask;
    assign kp_irq_d  = kp_pending & ~ctrl_q.kp_mask;

    // the two latches share one design
    irq_latch u_ext_latch (
        .clk       (pclk),
        .rst_n     (presetn),
        .low_in    (ext_low_w),
        .sense_sel (ctrl_q.ext_sense),
        .ack       (ack_ext_w),
        .pending   (ext_pending)
    );

    irq_latch u_kp_latch (
        .clk       (pclk),
        .rst_n     (presetn),
        .low_in    (kp_low_w),
        .sense_sel (ctrl_q.kp_sense),
        .ack       (ack_kp_w),
        .pending   (kp_pending)
    );

    // two-stage synchroniser for the pins; idle level is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= kbi_pkg::PIN_IDLE;
            sync2_q <= kbi_pkg::PIN_IDLE;
        end else begin
            sync1_q <= {ext_pin_n, kp_pin};
            sync2_q <= sync1_q;
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= kbi_pkg::CTRL_RESET;
            kp_en_q <= kbi_pkg::KP_EN_RESET;
        end else begin
            ctrl_q  <= ctrl_d;
            kp_en_q <= kp_en_d;
        end
    end

    // apb answer registered in setup, so pready rises in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pready  <= setup_w;
            pslverr <= setup_w & ~(hit_sc_w | hit_en_w);
        end
    end

    // registered requests and pin controls
    // wake needs pclk running; a stopped clock must be gated by the caller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_req  <= 1'b0;
            kp_irq_req   <= 1'b0;
            wake_req     <= 1'b0;
            pullup_en    <= 6'h00;
            pin_oe       <= 6'h00;
            pin_read_sel <= 6'h3f;
        end else begin
            ext_irq_req  <= ext_irq_d;
            kp_irq_req   <= kp_irq_d;
            wake_req     <= ext_irq_d | kp_irq_d;
            pullup_en    <= kp_en_q;
            pin_oe       <= port_direction & ~kp_en_q;
            pin_read_sel <= ~port_direction;
        end
    end

    sequence s_read_sc;
        setup_w && !pwrite && hit_sc_w;
    endsequence
    property p_flag_read;
        @(posedge pclk) disable iff (!presetn)
            s_read_sc |=> prdata[7] == $past(ext_pending) && prdata[3] == $past(kp_pending);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("pending flags misread");

    property p_ack_reads_zero;
        @(posedge pclk) disable iff (!presetn)
            s_read_sc |=> prdata[6] == 1'b0 && prdata[2] == 1'b0 && pready;
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("ack bit read as one");

    property p_kp_flag_mirror;
        @(posedge pclk) disable iff (!presetn)
            kp_irq_req |-> $past(kp_pending);
    endproperty
    a_kp_flag_mirror: assert property (p_kp_flag_mirror)
        else $error("keypad request without pending latch");

    property p_ext_mask;
        @(posedge pclk) disable iff (!presetn)
            ext_irq_req == $past(ext_pending && !ctrl_q.ext_mask);
    endproperty
    a_ext_mask: assert property (p_ext_mask)
        else $error("external request ignores mask");

    property p_kp_mask;
        @(posedge pclk) disable iff (!presetn)
            (ctrl_q.kp_mask && $past(ctrl_q.kp_mask)) |-> !kp_irq_req;
    endproperty
    a_kp_mask: assert property (p_kp_mask)
        else $error("masked keypad request reached cpu");

    property p_break_hold;
        @(posedge pclk) disable iff (!presetn)
            // level mode may legally finish an ack remembered from before break
            (wr_sc_w && break_active && !break_clear_enable && !vec_ack_ext && ext_pending
             && !ctrl_q.ext_sense)
            |=> ext_pending;
    endproperty
    a_break_hold: assert property (p_break_hold)
        else $error("ack during break cleared latch");

    property p_force_input;
        @(posedge pclk) disable iff (!presetn)
            (kp_en_q != 6'h00) |=> (pin_oe & $past(kp_en_q)) == 6'h00;
    endproperty
    a_force_input: assert property (p_force_input)
        else $error("enabled keypad pin driven as output");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
            wake_req == (ext_irq_req || kp_irq_req);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake does not follow unmasked requests");

    property p_reserved_write;
        @(posedge pclk) disable iff (!presetn)
            wr_sc_w |=> ctrl_q == {$past(pwdata[5:4]), $past(pwdata[1:0])};
    endproperty
    a_reserved_write: assert property (p_reserved_write)
        else $error("control write stored wrong bits");

    property p_pullup;
        @(posedge pclk) disable iff (!presetn)
            $past(presetn) |-> pullup_en == $past(kp_en_q);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pullup does not follow keypad enable");

    property p_read_sel;
        @(posedge pclk) disable iff (!presetn)
            $past(presetn) |-> pin_read_sel == ~$past(port_direction);
    endproperty
    a_read_sel: assert property (p_read_sel)
        else $error("pin read select ignores direction");

    // one answer per setup; a stuck pready would double-commit writes
    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
            pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held longer than one cycle");

    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
            pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("slave error without ready");
endmodule
`default_nettype wire

// ==== tb/kbi_pin_src.sv ====
// keypad switches and external request source on the far side of the pins
// assumes press and ext_low change just after rising pclk edges
`timescale 1ns/1ps
`default_nettype none
module kbi_pin_src (
    // clock
    input  wire logic       pclk,
    // stimulus and pull control
    input  wire logic [5:0] press,
    input  wire logic       ext_low,
    input  wire logic [5:0] pullup_en,
    // pins
    output logic            ext_pin_n,
    output logic      [5:0] kp_pin
);
    logic [5:0] float_q = 6'h2a;

    // open lines without pullup wander, so a stale level never looks pulled
    always_ff @(posedge pclk) float_q <= ~float_q;
    // a closed switch pulls low; an open pin rests high only with pullup
    assign kp_pin    = ~press & (pullup_en | float_q);
    assign ext_pin_n = ~ext_low;
endmodule
`default_nettype wire

// ==== tb/keypad_irq_interrupt_unit_tb_top.sv ====
// self-checking bench for the keypad and external-pin interrupt unit
// assumes an apb slave that may insert wait states; pins via switch model
`timescale 1ns/1ps
`default_nettype none
module keypad_irq_interrupt_unit_tb_top;
    localparam logic [11:0] SC = kbi_pkg::ADDR_STATUS_CTRL;
    localparam logic [11:0] EN = kbi_pkg::ADDR_PIN_ENABLE;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, ext_pin_n, ext_low = 1'b0;
    logic [5:0]  kp_pin, press = 6'h00, port_direction = 6'h00;
    logic        vec_ack_ext = 1'b0, vec_ack_kp = 1'b0;
    logic        break_active = 1'b0, break_clear_enable = 1'b0;
    logic        ext_irq_req, kp_irq_req, wake_req;
    logic [5:0]  pullup_en, pin_oe, pin_read_sel;
    int          error_cnt = 0, num_checks = 0;

    kbi_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_pin_n(ext_pin_n), .kp_pin(kp_pin),
        .vec_ack_ext(vec_ack_ext), .vec_ack_kp(vec_ack_kp), .break_active(break_active),
        .break_clear_enable(break_clear_enable), .port_direction(port_direction),
        .ext_irq_req(ext_irq_req), .kp_irq_req(kp_irq_req), .wake_req(wake_req),
        .pullup_en(pullup_en), .pin_oe(pin_oe), .pin_read_sel(pin_read_sel));
    kbi_pin_src u_src (.pclk(pclk), .press(press), .ext_low(ext_low),
        .pullup_en(pullup_en), .ext_pin_n(ext_pin_n), .kp_pin(kp_pin));

    // 25 mhz
    initial begin
        forever #20 pclk = ~pclk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one transfer; an idle cycle after it keeps strobes single-driven per step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] e, input logic ee);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
        chk(prdata, e);
        chk(32'(pslverr), 32'(ee));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    // main sequence; pin waits of six cycles cover sync plus latch
    initial begin
        tick(12);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(SC, 32'h0);
        rd(EN, 32'h0);
        chk(32'(pin_read_sel), 32'h3f);
        apb(1'b0, 12'h070, 32'h0, 32'h0, 1'b1);
        wr(SC, 32'hff);
        rd(SC, 32'h33);
        wr(SC, 32'h0);
        $display("test registers done");
        ext_low <= 1'b1;
        tick(6);
        rd(SC, 32'h80);
        chk(32'({ext_irq_req, wake_req}), 32'h3);
        ext_low <= 1'b0;
        tick(6);
        rd(SC, 32'h80);
        wr(SC, 32'h40);
        rd(SC, 32'h0);
        wr(SC, 32'h20);
        ext_low <= 1'b1;
        tick(6);
        rd(SC, 32'ha0);
        chk(32'(ext_irq_req), 32'h0);
        ext_low <= 1'b0;
        vec_ack_ext <= 1'b1;
        tick(1);
        vec_ack_ext <= 1'b0;
        tick(2);
        rd(SC, 32'h20);
        wr(SC, 32'h10);
        ext_low <= 1'b1;
        tick(6);
        wr(SC, 32'h50);
        rd(SC, 32'h90);
        ext_low <= 1'b0;
        tick(6);
        rd(SC, 32'h10);
        $display("test external pin done");
        // masked enable first, then settle, ack and unmask
        wr(SC, 32'h02);
        wr(EN, 32'h7e);
        tick(6);
        wr(SC, 32'h06);
        wr(SC, 32'h0);
        rd(SC, 32'h0);
        press <= 6'h01;
        tick(6);
        rd(SC, 32'h08);
        chk(32'({kp_irq_req, wake_req}), 32'h3);
        wr(SC, 32'h04);
        press <= 6'h03;
        tick(6);
        rd(SC, 32'h0);
        press <= 6'h00;
        tick(6);
        press <= 6'h04;
        tick(6);
        rd(SC, 32'h08);
        wr(SC, 32'h02);
        rd(SC, 32'h0a);
        chk(32'({kp_irq_req, wake_req}), 32'h0);
        break_active <= 1'b1;
        wr(SC, 32'h06);
        rd(SC, 32'h0a);
        break_clear_enable <= 1'b1;
        wr(SC, 32'h06);
        break_active <= 1'b0;
        break_clear_enable <= 1'b0;
        tick(2);
        rd(SC, 32'h02);
        press <= 6'h00;
        tick(6);
        press <= 6'h08;
        tick(6);
        rd(SC, 32'h0a);
        vec_ack_kp <= 1'b1;
        tick(1);
        vec_ack_kp <= 1'b0;
        tick(2);
        rd(SC, 32'h02);
        // keypad level mode: ack while held low keeps the request
        wr(SC, 32'h03);
        press <= 6'h00;
        tick(6);
        press <= 6'h08;
        tick(6);
        wr(SC, 32'h07);
        rd(SC, 32'h0b);
        press <= 6'h00;
        tick(6);
        rd(SC, 32'h03);
        $display("test keypad done");
        port_direction <= 6'h3f;
        wr(EN, 32'h0e);
        tick(2);
        chk(32'(pin_oe), 32'h38);
        chk(32'(pullup_en), 32'h07);
        chk(32'(pin_read_sel), 32'h0);
        $display("test port pins done");
        end_of_test();
    end
endmodule
`default_nettype wire
